// ---- hw/pi_loop_pkg.sv ----
/*
 * constants for the pi loop controller: register map, field positions,
 * reset values, scaling and sample timing, preset encodings.
 * assumes a 200 mhz system clock and a 32-bit classic wishbone master.
 */
package pi_loop_pkg;
    // byte offsets of the word registers
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] meas_min_off = 8'h04;
    localparam logic [7:0] meas_max_off = 8'h08;
    localparam logic [7:0] meas_gain_off = 8'h0C;
    localparam logic [7:0] meas_offset_off = 8'h10;
    localparam logic [7:0] setpoint_off = 8'h14;
    localparam logic [7:0] manual_off = 8'h18;
    localparam logic [7:0] loop_gain_off = 8'h1C;
    localparam logic [7:0] integral_time_off = 8'h20;
    localparam logic [7:0] preset_off = 8'h24;
    localparam logic [7:0] status_off = 8'h28;
    localparam logic [7:0] meas_cond_off = 8'h2C;
    localparam logic [7:0] integral_off = 8'h30;
    // control register fields
    localparam int ctrl_auto_bit = 0;
    localparam int ctrl_clear_bit = 1;
    localparam int ctrl_dir_bit = 2;
    // reset values
    localparam logic [15:0] meas_min_rst = 16'hD8F0; // -10000
    localparam logic [15:0] meas_max_rst = 16'h4E20; // +20000
    localparam logic [15:0] meas_gain_rst = 16'h0064; // 1.00
    localparam logic [15:0] meas_offset_rst = 16'h0000;
    localparam logic [15:0] setpoint_rst = 16'h0000;
    localparam logic [15:0] manual_rst = 16'h0000;
    localparam logic [15:0] loop_gain_rst = 16'h0064; // 1.00
    localparam logic [15:0] integral_time_rst = 16'h0078; // 120 s
    // scaling: gains in hundredths, integral time in seconds
    localparam int gain_scale = 100;
    localparam logic [15:0] integral_off_time = 16'h176F; // 99:59 = 5999 s
    localparam int out_min = 0;
    localparam int out_max = 1000;
    localparam int frac_bits = 16;
    // sample timing
    localparam longint clk_hz = 200_000_000;
    localparam longint sample_time_ms = 500;
    localparam int sample_cycles = int'(clk_hz * sample_time_ms / 1000);
    localparam int samples_per_s = int'(1000 / sample_time_ms);
    // preset selectors
    localparam logic [2:0] preset_temp_fast = 3'h0;
    localparam logic [2:0] preset_temp_slow = 3'h1;
    localparam logic [2:0] preset_press_quick = 3'h2;
    localparam logic [2:0] preset_press_slow = 3'h3;
    localparam logic [2:0] preset_level_nodrain = 3'h4;
    localparam logic [2:0] preset_level_drain = 3'h5;
endpackage

// ---- hw/pi_loop_controller.sv ----
/*
 * pi loop controller: conditions a raw analog process value, compares it
 * with a setpoint each 500 ms sample and drives a 0..1000 output in auto; manual mode passes the manual value unclamped.
 * assumes a classic wishbone master on mclk and a raw sample input that
 * is asynchronous to mclk (held steady long enough to pass a two-flop
 * synchroniser coherently).
 */
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
module pi_loop_controller
    import pi_loop_pkg::*;
#(
    parameter int sample_period = sample_cycles // shorten in simulation
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] process_value,
    output logic [15:0] analog_output
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic [15:0] raw_meta; // first synchroniser stage only
    logic [15:0] raw_sync; // safe copy of the sensor value
    logic [31:0] tick_cnt; // sample period counter
    logic tick; // one-cycle sample strobe
    logic auto_sel; // software auto/manual select
    logic clear_sel; // software clear input
    logic dir_neg; // action direction, 1 = negative
    logic [15:0] meas_min;
    logic [15:0] meas_max;
    logic [15:0] meas_gain; // signed hundredths
    logic [15:0] meas_offset;
    logic [15:0] setpoint_value;
    logic [15:0] manual_output_value;
    logic [15:0] loop_gain; // hundredths, 0..9999
    logic [15:0] integral_time; // seconds
    logic in_auto; // mode actually running
    logic signed [47:0] integ; // integral sum with fraction bits
    logic [15:0] meas_cond; // last conditioned value
    logic wr_now; // write takes effect this edge
    logic [31:0] next_rdata;
    logic signed [31:0] meas_scaled;
    logic signed [31:0] meas_clamped;
    logic signed [31:0] err;
    logic signed [31:0] kp;
    logic signed [31:0] ki;
    logic signed [47:0] p_part;
    logic signed [47:0] i_step;
    logic signed [47:0] next_integ;
    logic signed [47:0] out_sum;
    logic [15:0] next_out;

    localparam logic signed [47:0] integ_hi = 48'(out_max) <<< frac_bits;
    localparam logic signed [47:0] integ_lo = 48'(out_min) <<< frac_bits;

    ////////////////////////////////////////////////////////////////////
    // sensor input synchroniser

    // two flops before anything looks at the pin
    always_ff @(posedge mclk)
    begin
        raw_meta <= process_value;
        raw_sync <= raw_meta;
    end

    ////////////////////////////////////////////////////////////////////
    // sample tick

    // free-running divider, tick on the terminal count
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end
        else if (tick_cnt == 32'(sample_period - 1))
        begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
            tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wishbone slave

    // the write lands on the edge where ack is seen high
    assign wr_now = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;

    // single-wait-state ack, dropped the cycle after
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end

    // read mux; unmapped offsets read as zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            ctrl_off: next_rdata = {29'h0, dir_neg, clear_sel, auto_sel};
            meas_min_off: next_rdata = {16'h0000, meas_min};
            meas_max_off: next_rdata = {16'h0000, meas_max};
            meas_gain_off: next_rdata = {16'h0000, meas_gain};
            meas_offset_off: next_rdata = {16'h0000, meas_offset};
            setpoint_off: next_rdata = {16'h0000, setpoint_value};
            manual_off: next_rdata = {16'h0000, manual_output_value};
            loop_gain_off: next_rdata = {16'h0000, loop_gain};
            integral_time_off: next_rdata = {16'h0000, integral_time};
            status_off: next_rdata = {15'h0000, in_auto, analog_output};
            meas_cond_off: next_rdata = {16'h0000, meas_cond};
            integral_off: next_rdata = {16'h0000, integ[31:16]};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // read data captured with the ack
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            wb_dat_o <= 32'h0000_0000;
        else if (wb_cyc_i & wb_stb_i & ~wb_ack_o)
            wb_dat_o <= next_rdata;
    end

    // configuration registers; byte lanes 0 and 1 only carry data
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            auto_sel <= 1'b0;
            clear_sel <= 1'b0;
            dir_neg <= 1'b0;
            meas_min <= meas_min_rst;
            meas_max <= meas_max_rst;
            meas_gain <= meas_gain_rst;
            meas_offset <= meas_offset_rst;
            setpoint_value <= setpoint_rst;
            manual_output_value <= manual_rst;
            loop_gain <= loop_gain_rst;
            integral_time <= integral_time_rst;
        end
        else if (wr_now & wb_sel_i[0])
        begin
            unique case (wb_adr_i)
                ctrl_off:
                begin
                    auto_sel <= wb_dat_i[ctrl_auto_bit];
                    clear_sel <= wb_dat_i[ctrl_clear_bit];
                    dir_neg <= wb_dat_i[ctrl_dir_bit];
                end
                meas_min_off: meas_min <= wb_dat_i[15:0];
                meas_max_off: meas_max <= wb_dat_i[15:0];
                meas_gain_off: meas_gain <= wb_dat_i[15:0];
                meas_offset_off: meas_offset <= wb_dat_i[15:0];
                setpoint_off: setpoint_value <= wb_dat_i[15:0];
                manual_off: manual_output_value <= wb_dat_i[15:0];
                loop_gain_off: loop_gain <= wb_dat_i[15:0];
                integral_time_off: integral_time <= wb_dat_i[15:0];
                preset_off:
                begin
                    // presets set gain and time, direction always positive
                    dir_neg <= 1'b0;
                    unique case (wb_dat_i[2:0])
                        preset_temp_fast:
                        begin
                            loop_gain <= 16'h0032;
                            integral_time <= 16'h001E;
                        end
                        preset_temp_slow:
                        begin
                            loop_gain <= 16'h0064;
                            integral_time <= 16'h0078;
                        end
                        preset_press_quick:
                        begin
                            loop_gain <= 16'h012C;
                            integral_time <= 16'h0005;
                        end
                        preset_press_slow:
                        begin
                            loop_gain <= 16'h0078;
                            integral_time <= 16'h000C;
                        end
                        preset_level_nodrain:
                        begin
                            loop_gain <= 16'h0064;
                            integral_time <= 16'h0001;
                        end
                        preset_level_drain:
                        begin
                            loop_gain <= 16'h0046;
                            integral_time <= 16'h0014;
                        end
                        // codes 6 and 7 only force the direction
                        default: loop_gain <= loop_gain;
                    endcase
                end
                default: auto_sel <= auto_sel;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control arithmetic, evaluated every cycle, used on the tick

    always_comb
    begin
        // scale and shift the raw sample
        meas_scaled = 32'($signed(raw_sync)) * 32'($signed(meas_gain)) / gain_scale
            + 32'($signed(meas_offset));
        if (meas_scaled > 32'($signed(meas_max)))
            meas_clamped = 32'($signed(meas_max));
        else if (meas_scaled < 32'($signed(meas_min)))
            meas_clamped = 32'($signed(meas_min));
        else
            meas_clamped = meas_scaled;
        // signed error, inverted for reverse action
        err = 32'($signed(setpoint_value)) - meas_clamped;
        if (dir_neg)
            err = -err;
        // zero gain turns p off and leaves unity on the integral
        kp = (loop_gain == 16'h0000) ? 32'sd0 : $signed({16'h0000, loop_gain});
        ki = (loop_gain == 16'h0000) ? 32'(gain_scale)
            : $signed({16'h0000, loop_gain});
        // p part in output units with fraction bits
        p_part = (48'(kp * err) <<< frac_bits) / gain_scale;
        // ki * (ts/ti) * e, ts = 1/samples_per_s seconds
        if (integral_time == integral_off_time || integral_time == 16'h0000)
            i_step = 48'sd0;
        else
            i_step = (48'(ki * err) <<< frac_bits)
                / (48'(gain_scale * samples_per_s) * $signed({32'h0, integral_time}));
        // anti-windup: sum held inside the output span
        next_integ = integ + i_step;
        if (next_integ > integ_hi)
            next_integ = integ_hi;
        else if (next_integ < integ_lo)
            next_integ = integ_lo;
        out_sum = (p_part + next_integ) >>> frac_bits;
        if (out_sum > 48'(out_max))
            next_out = 16'(out_max);
        else if (out_sum < 48'(out_min))
            next_out = 16'(out_min);
        else
            next_out = out_sum[15:0];
    end

    ////////////////////////////////////////////////////////////////////
    // mode, integral sum and output

    // clear wins over everything but reset and drops back out of auto, so a later
    // release with auto selected reloads the sum from the manual value
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            in_auto <= 1'b0;
            integ <= 48'sd0;
            analog_output <= 16'h0000;
            meas_cond <= 16'h0000;
        end
        else if (clear_sel)
        begin
            in_auto <= 1'b0;
            analog_output <= 16'h0000;
        end
        else if (tick)
        begin
            meas_cond <= meas_clamped[15:0];
            if (!auto_sel)
            begin
                in_auto <= 1'b0;
                analog_output <= manual_output_value;
            end
            else if (!in_auto)
            begin
                // first auto sample: seed the sum, compute from the next
                in_auto <= 1'b1;
                integ <= 48'($signed({16'h0000, manual_output_value})) <<< frac_bits;
            end
            else if (err == 32'sd0)
                analog_output <= analog_output;
            else
            begin
                // corrects on each sample while error remains
                integ <= next_integ;
                analog_output <= next_out;
            end
        end
    end

endmodule

// ---- dv/pi_loop_sva.sv ----
/*
 checker for pi_loop_controller port behaviour.
 assumes a classic wishbone master that leaves one idle cycle between requests.
*/
`timescale 1ns/1ps
module pi_loop_sva
    import pi_loop_pkg::*;
#(
    parameter int sample_period = sample_cycles
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [15:0] process_value,
    input wire logic [15:0] analog_output
);
    ////////////////////////////////////////////////////////////////////////////
    // phase of the sample tick, restarted by reset like the design's
    int phase;
    always_ff @(posedge mclk)
    begin
        if (sys_rst || phase == sample_period - 1)
            phase <= 0;
        else
            phase <= phase + 1;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////
    // request not yet answered
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // control write with clear set, taken at the ack edge
    sequence s_clear_wr;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ctrl_off && wb_dat_i[ctrl_clear_bit];
    endsequence
    a_ack_latency: assert property (s_req |=> wb_ack_o)
        else $error("ack did not follow request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_reset_quiet: assert property (disable iff (1'b0)
        sys_rst |=> !wb_ack_o && analog_output == 16'h0000)
        else $error("outputs active after reset");
    a_out_range: assert property (analog_output <= 16'h03E8)
        else $error("output above range");
    a_clear_zero: assert property (s_clear_wr |-> ##[1:2] analog_output == 16'h0000)
        else $error("clear did not zero output");
    // output only moves, except when cleared to zero, on the edge that closes the tick cycle (phase 0)
    a_tick_only: assert property ($changed(analog_output)
        && analog_output != 16'h0000 |-> phase == 1)
        else $error("output moved between ticks");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i
        && (wb_adr_i == preset_off || wb_adr_i > integral_off) |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule
bind pi_loop_controller pi_loop_sva #(.sample_period(sample_period)) pi_loop_sva_i (
    .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .process_value(process_value),
    .analog_output(analog_output));

// ---- dv/sensor_model.sv ----
/*
 sensor front end: presents a raw process level to the controller.
 assumes the bench sets the level; the value is held steady between changes.
*/
`timescale 1ns/1ps
module sensor_model
(
    input wire logic mclk,
    input wire logic [15:0] level,
    output logic [15:0] process_value
);
    // registered so the sample never moves mid-cycle
    always_ff @(posedge mclk)
    begin
        process_value <= level;
    end
endmodule

// ---- dv/tb_top.sv ----
/*
 self-checking bench for pi_loop_controller over wishbone.
 assumes a shortened sample period of 20 cycles.
*/
`timescale 1ns/1ps
module tb_top;
    import pi_loop_pkg::*;
    localparam int per = 20; // shortened tick
    logic mclk = 0;
    logic sys_rst = 1;
    logic cyc = 0;
    logic stb = 0;
    logic we = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic [15:0] level = 16'h0000;
    logic [15:0] sensed;
    logic [15:0] aout;
    logic [15:0] o1;
    int num_errors = 0;
    int num_checks = 0;
    // register offsets with their reset values, and preset gain/time tables
    localparam logic [7:0] offs [8] = '{meas_min_off, meas_max_off, meas_gain_off,
        meas_offset_off, setpoint_off, manual_off, loop_gain_off, integral_time_off};
    localparam logic [15:0] rsts [8] = '{meas_min_rst, meas_max_rst, meas_gain_rst,
        meas_offset_rst, setpoint_rst, manual_rst, loop_gain_rst, integral_time_rst};
    localparam logic [15:0] pg [6] = '{16'h0032, 16'h0064, 16'h012C, 16'h0078, 16'h0064,
        16'h0046};
    localparam logic [15:0] pt [6] = '{16'h001E, 16'h0078, 16'h0005, 16'h000C, 16'h0001,
        16'h0014};
    always #2.5 mclk = ~mclk;
    sensor_model sensor_model_i (.mclk(mclk), .level(level), .process_value(sensed));
    pi_loop_controller #(.sample_period(per)) pi_loop_controller_i (.mclk(mclk),
        .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .process_value(sensed), .analog_output(aout));
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (num_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one classic cycle; values read right after the edge are the sampled ones;
    // waits for ack however long it takes, only the watchdog ends a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do
            @(posedge mclk);
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(0, a, 32'h0000_0000, q);
    endtask
    task automatic ticks(input int n);
        repeat (n * per) @(posedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [31:0] q;
        repeat (8) @(posedge mclk);
        sys_rst <= 0;
        for (int i = 0; i < 8; i++)
        begin
            rd(offs[i], q);
            check("reset value", {16'h0000, q[15:0]}, {16'h0000, rsts[i]});
        end
        wr(8'h34, 32'h0000_1234);
        rd(8'h34, q);
        check("unmapped", q, 32'h0000_0000);
        rd(preset_off, q);
        check("preset read", q, 32'h0000_0000);
        check("sample period", 32'(sample_cycles), 32'h05F5_E100);
        // manual mode drives the manual value
        wr(manual_off, 32'h0000_0190);
        ticks(2);
        check("manual out", {16'h0000, aout}, 32'h0000_0190);
        // clear wins over auto select
        wr(ctrl_off, 32'h0000_0003);
        ticks(2);
        check("clear out", {16'h0000, aout}, 32'h0000_0000);
        rd(status_off, q);
        check("clear mode", {31'h0, q[16]}, 32'h0000_0000);
        wr(ctrl_off, 32'h0000_0000);
        ticks(2);
        // conditioned value 300*2.00-100 equals setpoint 500
        level <= 16'd300;
        wr(meas_gain_off, 32'h0000_00C8);
        wr(meas_offset_off, 32'h0000_FF9C);
        wr(setpoint_off, 32'h0000_01F4);
        wr(integral_time_off, 32'h0000_0001);
        wr(ctrl_off, 32'h0000_0001);
        ticks(3);
        check("auto entry out", {16'h0000, aout}, 32'h0000_0190);
        rd(integral_off, q);
        check("integral seed", {16'h0000, q[15:0]}, 32'h0000_0190);
        rd(meas_cond_off, q);
        check("conditioned", {16'h0000, q[15:0]}, 32'h0000_01F4);
        // reading above setpoint: positive lowers, negative raises, checked every second sample
        level <= 16'd350;
        o1 = 16'd400;
        for (int i = 0; i < 3; i++)
        begin
            ticks(2);
            check("pos falls", 32'(aout < o1), 32'h1);
            o1 = aout;
        end
        wr(ctrl_off, 32'h0000_0005);
        for (int i = 0; i < 3; i++)
        begin
            ticks(2);
            check("neg rises", 32'(aout > o1), 32'h1);
            o1 = aout;
        end
        // clamp to maximum, then saturate at the top of the range
        wr(meas_max_off, 32'h0000_03E8);
        level <= 16'h07D0;
        ticks(2);
        rd(meas_cond_off, q);
        check("max clamp", {16'h0000, q[15:0]}, 32'h0000_03E8);
        for (int i = 0; i < 12000 && aout !== 16'd1000; i++)
            @(posedge mclk);
        ticks(2);
        check("saturated", {16'h0000, aout}, 32'h0000_03E8);
        rd(integral_off, q);
        check("integ limit", {16'h0000, q[15:0]}, 32'h0000_03E8);
        // zero gain with integral off: output holds despite error
        wr(loop_gain_off, 32'h0000_0000);
        wr(integral_time_off, {16'h0000, integral_off_time});
        wr(meas_min_off, 32'h0000_FFCE);
        level <= 16'hFF00;
        ticks(4);
        rd(meas_cond_off, q);
        check("min clamp", {16'h0000, q[15:0]}, 32'h0000_FFCE);
        check("hold", {16'h0000, aout}, 32'h0000_03E8);
        // zero gain keeps unity integral action
        wr(integral_time_off, 32'h0000_0001);
        ticks(4);
        check("ki one", 32'(aout < 16'd1000), 32'h1);
        // presets load gain and time and force positive direction
        for (int i = 0; i < 6; i++)
        begin
            wr(preset_off, 32'(i));
            rd(loop_gain_off, q);
            check("preset gain", {16'h0000, q[15:0]}, {16'h0000, pg[i]});
            rd(integral_time_off, q);
            check("preset time", {16'h0000, q[15:0]}, {16'h0000, pt[i]});
            rd(ctrl_off, q);
            check("preset dir", {31'h0, q[ctrl_dir_bit]}, 32'h0);
            wr(ctrl_off, 32'h0000_0005);
        end
        complete_run();
    end
    // watchdog well beyond the expected run
    initial
    begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        complete_run();
    end
endmodule
